// ---- can_fifo_regs.vh ----
`ifndef CAN_FIFO_REGS_VH
`define CAN_FIFO_REGS_VH

// register byte offsets
`define OFS_FIFO_CONTROL 4'h0
`define OFS_FIFO_STATUS 4'h4
`define OFS_USER_ADDRESS 4'h8

// control field positions
`define CTL_PAYLOAD_HI 31
`define CTL_PAYLOAD_LO 29
`define CTL_DEPTH_HI 28
`define CTL_DEPTH_LO 24
`define CTL_FIFO_RESET 10
`define CTL_SEND_REQ 9
`define CTL_PTR_ADVANCE 8
`define CTL_DIRECTION 7
`define CTL_AUTO_RTR 6
`define CTL_RX_TSTAMP 5

// status field positions
`define STA_INDEX_HI 12
`define STA_INDEX_LO 8
`define STA_ABORTED 7
`define STA_LOST_ARB 6
`define STA_BUS_ERR 5
`define STA_ATTEMPTS 4
`define STA_OVERFLOW 3

// reset values
`define RST_FIFO_RESET 1'b1
`define RST_DEPTH 5'h00
`define RST_PAYLOAD 3'h0

// engine event codes
`define EV_RX_STORE 4'h1
`define EV_RX_OVERFLOW 4'h2
`define EV_TX_DONE 4'h3
`define EV_TX_ABORTED 4'h4
`define EV_TX_LOST_ARB 4'h5
`define EV_TX_BUS_ERR 4'h6
`define EV_TX_ATTEMPTS 4'h7
`define EV_REMOTE_REQ 4'h8

// message object layout in bytes
`define OBJ_HEADER_BYTES 8'h08
`define OBJ_TSTAMP_BYTES 8'h04

// event buffer shape
`define EVQ_WIDTH 4
`define EVQ_DEPTH 16
`define EVQ_AW 4

`endif

// ---- can_message_fifo_ctrl_status.v ----
// How it works
// - writing one resets FIFO, self-clears
// - reset bit held in configuration mode
// - send request clears when queue sent
// - clearing pending send request aborts message
// - send request ignored for receive FIFO
// - transmit advance moves head one slot
// - receive advance moves tail one slot
// - direction bit: one transmit, zero receive
// - direction, timestamp writable only in configuration
// - remote request sets send request if enabled
// - timestamp capture follows enable bit, zero in transmit
// - five enables gate interrupt sources
// - message index gives next slot
// - aborted, lost arbitration, bus error status
// - outcome bits change on completion or reset
// - outcome bits clear on request or zero-write
// - attempts exhausted flag, zero in receive
// - overflow flag, zero in transmit
// - empty/full flag per direction
// - half level flag per direction
// - not full/not empty flag per direction
// - status upper bits read zero
// - depth field gives value plus one
// - user address: head transmit, tail receive
`timescale 1ns/1ps
`include "can_fifo_regs.vh"
module can_message_fifo_ctrl_status (
  input wire core_clk,
  input wire nrst,
  input wire configMode,
  input wire [3:0] regAddr,
  input wire regWe,
  input wire regRe,
  input wire [3:0] regBe,
  input wire [31:0] regWdata,
  output reg [31:0] regRdata,
  input wire [31:0] ramBase,
  input wire evValid,
  output wire evReady,
  input wire [3:0] evCode,
  output wire sendPending,
  output reg abortRequest,
  output wire captureTimestamp,
  output wire txMode,
  output wire [4:0] messageIndex,
  output wire [31:0] userAddress,
  output wire intReq
);
  reg fifoReset_reg;
  reg sendReq_reg;
  reg direction_reg;
  reg autoRtr_reg;
  reg rxTstamp_reg;
  reg [4:0] intEn_reg;
  reg [4:0] depth_reg;
  reg [2:0] payload_reg;
  reg [4:0] head_reg;
  reg [4:0] tail_reg;
  reg [5:0] count_reg;
  reg aborted_reg;
  reg lostArb_reg;
  reg busErr_reg;
  reg attempts_reg;
  reg overflow_reg;
  reg [7:0] payloadBytes;
  wire [5:0] capacity;
  wire full;
  wire empty;
  wire resetNow;
  wire qValid;
  wire qReady;
  wire [3:0] qCode;
  wire evFire;
  wire ctlWr;
  wire staWr;
  wire emptyFull;
  wire halfLevel;
  wire notFullNotEmpty;
  wire [4:0] flags;
  wire [31:0] controlWord;
  wire [31:0] statusWord;
  wire [7:0] objBytes;
  wire [12:0] objOffset;
  wire [4:0] headNext;
  wire [4:0] tailNext;
  wire [4:0] slot;
  wire [7:0] tsBytes;
  wire byte1Wr;
  wire hostAdv;
  wire incCount;
  wire decCount;
  wire evRxStore;
  wire evRxOverflow;
  wire evTxDone;
  wire evTxAborted;
  wire evTxLostArb;
  wire evTxBusErr;
  wire evTxAttempts;
  wire evRemoteReq;

  assign capacity = {1'b0, depth_reg} + 6'h01;
  // up to 32 messages, so a sixth count bit keeps full apart from empty
  assign full = (count_reg == capacity);
  assign empty = (count_reg == 6'h00);
  assign headNext = (head_reg == depth_reg) ? 5'h00 : head_reg + 5'h01;
  assign tailNext = (tail_reg == depth_reg) ? 5'h00 : tail_reg + 5'h01;
  // reset carried out once out of configuration
  assign resetNow = fifoReset_reg & ~configMode;
  assign ctlWr = regWe & (regAddr == `OFS_FIFO_CONTROL);
  assign staWr = regWe & (regAddr == `OFS_FIFO_STATUS);
  assign txMode = direction_reg;
  assign sendPending = sendReq_reg;
  assign captureTimestamp = rxTstamp_reg & ~direction_reg;
  // next to send or next save slot
  assign messageIndex = direction_reg ? tail_reg : head_reg;

  // engine events wait here while the FIFO is held in reset
  assign qReady = ~fifoReset_reg;
  assign evFire = qValid & qReady;
  // one strobe per engine event, gated by the direction it belongs to
  assign evRxStore = evFire & (qCode == `EV_RX_STORE) & ~direction_reg;
  assign evRxOverflow = evFire & (qCode == `EV_RX_OVERFLOW) & ~direction_reg;
  assign evTxDone = evFire & (qCode == `EV_TX_DONE) & direction_reg;
  assign evTxAborted = evFire & (qCode == `EV_TX_ABORTED) & direction_reg;
  assign evTxLostArb = evFire & (qCode == `EV_TX_LOST_ARB) & direction_reg;
  assign evTxBusErr = evFire & (qCode == `EV_TX_BUS_ERR) & direction_reg;
  assign evTxAttempts = evFire & (qCode == `EV_TX_ATTEMPTS) & direction_reg;
  assign evRemoteReq = evFire & (qCode == `EV_REMOTE_REQ) & direction_reg;
  assign byte1Wr = ctlWr & regBe[1];
  assign hostAdv = byte1Wr & regWdata[`CTL_PTR_ADVANCE];
  // one adder, so a host move and an engine move in one cycle cancel
  assign incCount = (hostAdv & direction_reg & ~full) | (evRxStore & ~full);
  assign decCount = (hostAdv & ~direction_reg & ~empty) | (evTxDone & ~empty);

  event_fifo #(
    .WIDTH(`EVQ_WIDTH),
    .DEPTH(`EVQ_DEPTH),
    .AW(`EVQ_AW)
  ) u_evq (
    .core_clk(core_clk),
    .nrst(nrst),
    .inValid(evValid),
    .inReady(evReady),
    .inData(evCode),
    .outValid(qValid),
    .outReady(qReady),
    .outData(qCode)
  );

  fifo_level_flags u_flags (
    .txMode(direction_reg),
    .count(count_reg),
    .capacity(capacity),
    .emptyFull(emptyFull),
    .halfLevel(halfLevel),
    .notFullNotEmpty(notFullNotEmpty)
  );

  // attempts flag reads zero in receive
  // overflow flag reads zero in transmit
  assign flags = {attempts_reg & direction_reg, overflow_reg & ~direction_reg,
                  emptyFull, halfLevel, notFullNotEmpty};
  assign intReq = |(flags & intEn_reg);

  always @* begin
    case (payload_reg)
      3'h0: payloadBytes = 8'h08;
      3'h1: payloadBytes = 8'h0C;
      3'h2: payloadBytes = 8'h10;
      3'h3: payloadBytes = 8'h14;
      3'h4: payloadBytes = 8'h18;
      3'h5: payloadBytes = 8'h20;
      3'h6: payloadBytes = 8'h30;
      default: payloadBytes = 8'h40;
    endcase
  end

  // transmit objects carry no timestamp word
  assign tsBytes = captureTimestamp ? `OBJ_TSTAMP_BYTES : 8'h00;
  assign objBytes = `OBJ_HEADER_BYTES + payloadBytes + tsBytes;
  // head for transmit, tail for receive
  assign slot = direction_reg ? head_reg : tail_reg;
  // widened first so the largest offset keeps every bit
  assign objOffset = {8'h00, slot} * {5'h00, objBytes};
  assign userAddress = ramBase + {19'h0_0000, objOffset};

  assign controlWord = {payload_reg, depth_reg, 13'h0000, fifoReset_reg, sendReq_reg, 1'b0,
                        direction_reg, autoRtr_reg, rxTstamp_reg, intEn_reg};
  // outcome bits on the status word
  assign statusWord = {19'h0_0000, messageIndex, aborted_reg, lostArb_reg, busErr_reg, flags};

  // unmapped offsets read as zero
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 32'h0000_0000;
    end else if (regRe) begin
      if (regAddr == `OFS_FIFO_CONTROL) begin
        regRdata <= controlWord;
      end else if (regAddr == `OFS_FIFO_STATUS) begin
        regRdata <= statusWord;
      end else if (regAddr == `OFS_USER_ADDRESS) begin
        regRdata <= userAddress;
      end else begin
        regRdata <= 32'h0000_0000;
      end
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fifoReset_reg <= `RST_FIFO_RESET;
      sendReq_reg <= 1'b0;
      abortRequest <= 1'b0;
      direction_reg <= 1'b0;
      autoRtr_reg <= 1'b0;
      rxTstamp_reg <= 1'b0;
      intEn_reg <= 5'h00;
      depth_reg <= `RST_DEPTH;
      payload_reg <= `RST_PAYLOAD;
      head_reg <= 5'h00;
      tail_reg <= 5'h00;
      count_reg <= 6'h00;
      aborted_reg <= 1'b0;
      lostArb_reg <= 1'b0;
      busErr_reg <= 1'b0;
      attempts_reg <= 1'b0;
      overflow_reg <= 1'b0;
    end else begin
      // abort request lasts a single cycle
      abortRequest <= 1'b0;
      if (ctlWr && regBe[0]) begin
        intEn_reg <= regWdata[4:0];
        autoRtr_reg <= regWdata[`CTL_AUTO_RTR];
        if (configMode) begin
          direction_reg <= regWdata[`CTL_DIRECTION];
          rxTstamp_reg <= regWdata[`CTL_RX_TSTAMP];
        end
      end
      if (ctlWr && regBe[3] && configMode) begin
        depth_reg <= regWdata[`CTL_DEPTH_HI:`CTL_DEPTH_LO];
        payload_reg <= regWdata[`CTL_PAYLOAD_HI:`CTL_PAYLOAD_LO];
      end
      if (configMode || resetNow) begin
        // reset updates outcome bits and request
        fifoReset_reg <= configMode;
        head_reg <= 5'h00;
        tail_reg <= 5'h00;
        count_reg <= 6'h00;
        sendReq_reg <= 1'b0;
        aborted_reg <= 1'b0;
        lostArb_reg <= 1'b0;
        busErr_reg <= 1'b0;
        attempts_reg <= 1'b0;
        overflow_reg <= 1'b0;
      end else begin
        // writing one requests reset, zero ignored
        if (ctlWr && regBe[1] && regWdata[`CTL_FIFO_RESET]) begin
          fifoReset_reg <= 1'b1;
        end
        // zero-write clears outcome and sticky flags
        if (staWr && regBe[0]) begin
          if (!regWdata[`STA_ABORTED]) aborted_reg <= 1'b0;
          if (!regWdata[`STA_LOST_ARB]) lostArb_reg <= 1'b0;
          if (!regWdata[`STA_BUS_ERR]) busErr_reg <= 1'b0;
          if (!regWdata[`STA_ATTEMPTS]) attempts_reg <= 1'b0;
          if (!regWdata[`STA_OVERFLOW]) overflow_reg <= 1'b0;
        end
        // send request has no effect in receive
        if (ctlWr && regBe[1] && direction_reg) begin
          if (regWdata[`CTL_SEND_REQ]) begin
            sendReq_reg <= 1'b1;
            aborted_reg <= 1'b0;
            lostArb_reg <= 1'b0;
            busErr_reg <= 1'b0;
          end else if (sendReq_reg) begin
            // clearing pending request asks for abort
            abortRequest <= 1'b1;
          end
        end
        // head and tail advance; engine side and host side never move the same pointer
        if (hostAdv) begin
          if (direction_reg && !full) begin
            head_reg <= headNext;
          end else if (!direction_reg && !empty) begin
            tail_reg <= tailNext;
          end
        end
        // events are applied after host clears so a same-cycle set wins
        if (evRxStore && full) begin
          overflow_reg <= 1'b1;
        end else if (evRxStore) begin
          head_reg <= headNext;
        end
        if (evRxOverflow) begin
          overflow_reg <= 1'b1;
        end
        if (evTxDone && !empty) begin
          tail_reg <= tailNext;
          // clears once last queued message sent
          if (count_reg == 6'h01) begin
            sendReq_reg <= 1'b0;
          end
        end
        if (evTxAborted) begin
          aborted_reg <= 1'b1;
          sendReq_reg <= 1'b0;
        end
        if (evTxLostArb) begin
          lostArb_reg <= 1'b1;
        end
        if (evTxBusErr) begin
          busErr_reg <= 1'b1;
        end
        if (evTxAttempts) begin
          attempts_reg <= 1'b1;
          sendReq_reg <= 1'b0;
        end
        if (evRemoteReq && autoRtr_reg) begin
          sendReq_reg <= 1'b1;
          // a set request clears outcome bits
          aborted_reg <= 1'b0;
          lostArb_reg <= 1'b0;
          busErr_reg <= 1'b0;
        end
        // net change of both pointer movers
        count_reg <= count_reg + {5'h00, incCount} - {5'h00, decCount};
      end
    end
  end
endmodule

// ---- can_message_fifo_ctrl_status_properties.sv ----
`timescale 1ns/1ps
module can_message_fifo_ctrl_status_properties (
  input wire core_clk,
  input wire nrst,
  input wire configMode,
  input wire [3:0] regAddr,
  input wire regWe,
  input wire regRe,
  input wire [3:0] regBe,
  input wire [31:0] regWdata,
  input wire [31:0] regRdata,
  input wire [31:0] ramBase,
  input wire evValid,
  input wire evReady,
  input wire [3:0] evCode,
  input wire sendPending,
  input wire abortRequest,
  input wire captureTimestamp,
  input wire txMode,
  input wire [4:0] messageIndex,
  input wire [31:0] userAddress,
  input wire intReq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire ctlWr = regWe && regAddr == 4'h0;
  chk_status_upper: assert property (regRe && regAddr == 4'h4 |=> regRdata[31:13] == 19'h0)
    else $error("status upper bits not zero");
  chk_index_read: assert property (regRe && regAddr == 4'h4 |=> regRdata[12:8] == $past(messageIndex))
    else $error("status index differs from message index");
  chk_addr_read: assert property (regRe && regAddr == 4'h8 |=> regRdata == $past(userAddress))
    else $error("user address read mismatch");
  chk_dir_locked: assert property (!configMode |=> $stable(txMode))
    else $error("direction changed outside configuration");
  chk_ts_rx_only: assert property (captureTimestamp |-> !txMode)
    else $error("timestamp capture in transmit mode");
  chk_rx_send_ignored: assert property (!txMode && !sendPending && ctlWr && regBe[1] |=> !sendPending)
    else $error("send request set in receive mode");
  chk_abort_on_clear: assert property (txMode && sendPending && !configMode && ctlWr && regBe[1]
    && !regWdata[9] && !regWdata[10] |=> abortRequest)
    else $error("no abort after send request cleared");
  chk_abort_single: assert property (abortRequest |=> !abortRequest)
    else $error("abort pulse longer than one cycle");
  cov_abort: cover property (abortRequest);
  cov_int: cover property ($rose(intReq));
  cov_remote: cover property (evValid && evReady && evCode == 4'h8);
  cov_full: cover property (!evReady);
endmodule
bind can_message_fifo_ctrl_status can_message_fifo_ctrl_status_properties chk_u (.core_clk(core_clk), .nrst(nrst),
  .configMode(configMode), .regAddr(regAddr), .regWe(regWe), .regRe(regRe), .regBe(regBe), .regWdata(regWdata),
  .regRdata(regRdata), .ramBase(ramBase), .evValid(evValid), .evReady(evReady), .evCode(evCode),
  .sendPending(sendPending), .abortRequest(abortRequest), .captureTimestamp(captureTimestamp), .txMode(txMode),
  .messageIndex(messageIndex), .userAddress(userAddress), .intReq(intReq));

// ---- engine_model.sv ----
`timescale 1ns/1ps
module engine_model (
  input wire core_clk,
  input wire evReady,
  output reg evValid,
  output reg [3:0] evCode
);
  initial begin
    evValid = 1'b0;
    evCode = 4'h0;
  end
  // ready only moves on edges, so its value after an edge holds at the next
  task post(input [3:0] code);
    begin
      @(posedge core_clk) #1;
      evValid = 1'b1;
      evCode = code;
      while (evReady !== 1'b1) @(posedge core_clk) #1;
      @(posedge core_clk) #1;
      evValid = 1'b0;
      evCode = ~code;
    end
  endtask
endmodule

// ---- event_fifo.v ----
`timescale 1ns/1ps
module event_fifo #(
  parameter WIDTH = 4,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire core_clk,
  input wire nrst,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_reg;
  reg [AW-1:0] rdPtr_reg;
  reg [AW:0] fill_reg;
  wire push;
  wire pop;
  integer i;

  assign inReady = (fill_reg != DEPTH[AW:0]);
  assign outValid = (fill_reg != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_reg];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      fill_reg <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem[wrPtr_reg] <= inData;
        wrPtr_reg <= (wrPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_reg + 1'b1;
      end
      if (push && !pop) begin
        fill_reg <= fill_reg + 1'b1;
      end else if (pop && !push) begin
        fill_reg <= fill_reg - 1'b1;
      end
    end
  end
endmodule

// ---- fifo_level_flags.v ----
`timescale 1ns/1ps
module fifo_level_flags (
  input wire txMode,
  input wire [5:0] count,
  input wire [5:0] capacity,
  output wire emptyFull,
  output wire halfLevel,
  output wire notFullNotEmpty
);
  wire [6:0] twice;
  assign twice = {count, 1'b0};
  assign emptyFull = txMode ? (count == 6'h00) : (count == capacity);
  assign halfLevel = txMode ? (twice <= {1'b0, capacity}) : (twice >= {1'b0, capacity});
  assign notFullNotEmpty = txMode ? (count != capacity) : (count != 6'h00);
endmodule

// ---- tb_can_message_fifo_ctrl_status.sv ----
`timescale 1ns/1ps
`include "can_fifo_regs.vh"
module tb_can_message_fifo_ctrl_status;
  reg core_clk = 1'b0;
  reg nrst = 1'b0;
  reg configMode = 1'b1;
  reg [3:0] regAddr = 4'h0;
  reg regWe = 1'b0;
  reg regRe = 1'b0;
  reg [3:0] regBe = 4'h0;
  reg [31:0] regWdata = 32'h0000_0000;
  reg [31:0] ramBase = 32'h0000_0400;
  wire evValid, evReady, sendPending, abortRequest, captureTimestamp, txMode, intReq;
  wire [3:0] evCode;
  wire [4:0] messageIndex;
  wire [31:0] regRdata, userAddress;
  integer fail_count = 0;
  integer compares = 0;
  integer cycles = 0;
  integer i;
  always #5 core_clk = ~core_clk;
  can_message_fifo_ctrl_status dut_u (.core_clk(core_clk), .nrst(nrst), .configMode(configMode),
    .regAddr(regAddr), .regWe(regWe), .regRe(regRe), .regBe(regBe), .regWdata(regWdata), .regRdata(regRdata),
    .ramBase(ramBase), .evValid(evValid), .evReady(evReady), .evCode(evCode), .sendPending(sendPending),
    .abortRequest(abortRequest), .captureTimestamp(captureTimestamp), .txMode(txMode),
    .messageIndex(messageIndex), .userAddress(userAddress), .intReq(intReq));
  engine_model engine_u (.core_clk(core_clk), .evReady(evReady), .evValid(evValid), .evCode(evCode));
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      fail_count = fail_count + 1;
      report_and_stop;
    end
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [3:0] be, input [31:0] d);
    begin
      @(posedge core_clk) #1;
      regWe = 1'b1;
      regAddr = a;
      regBe = be;
      regWdata = d;
      @(posedge core_clk) #1;
      regWe = 1'b0;
      regWdata = ~d;
    end
  endtask
  task peek(input [3:0] a);
    begin
      @(posedge core_clk) #1;
      regRe = 1'b1;
      regAddr = a;
      @(posedge core_clk) #1;
      regRe = 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [31:0] mask, input [31:0] exp);
    begin
      peek(a);
      check(regRdata & mask, exp);
    end
  endtask
  task waitc(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  initial begin
    waitc(3);
    nrst = 1'b1;
    rd(4'h0, 32'hFFFF_FFFF, 32'h0000_0400);
    wr(4'h0, 4'h9, 32'h0300_0084);
    configMode = 1'b0;
    waitc(2);
    rd(4'h0, 32'hFFFF_FFFF, 32'h0300_0084);
    rd(4'h4, 32'hFFFF_FFFF, 32'h0000_0007);
    check(intReq, 1'h1);
    wr(4'h0, 4'h1, 32'h0000_0004);
    rd(4'h0, 32'hFFFF_FFFF, 32'h0300_0084);
    for (i = 0; i < 3; i = i + 1) wr(4'h0, 4'h2, 32'h0000_0100);
    rd(4'h4, 32'hFFFF_FFFF, 32'h0000_0001);
    rd(4'h8, 32'hFFFF_FFFF, 32'h0000_0430);
    wr(4'h0, 4'h2, 32'h0000_0100);
    wr(4'h0, 4'h2, 32'h0000_0100);
    rd(4'h4, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(4'h8, 32'hFFFF_FFFF, 32'h0000_0400);
    rd(4'hC, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test tx_queue done");
    wr(4'h0, 4'h2, 32'h0000_0200);
    engine_u.post(`EV_TX_DONE);
    waitc(3);
    rd(4'h4, 32'hFFFF_FFFF, 32'h0000_0101);
    check(sendPending, 1'h1);
    for (i = 0; i < 3; i = i + 1) engine_u.post(`EV_TX_DONE);
    waitc(3);
    check(sendPending, 1'h0);
    wr(4'h0, 4'h2, 32'h0000_0100);
    wr(4'h0, 4'h2, 32'h0000_0200);
    wr(4'h0, 4'h2, 32'h0000_0000);
    check(abortRequest, 1'h1);
    engine_u.post(`EV_TX_ABORTED);
    waitc(3);
    rd(4'h4, 32'h0000_0080, 32'h0000_0080);
    wr(4'h0, 4'h2, 32'h0000_0200);
    rd(4'h4, 32'h0000_0080, 32'h0000_0000);
    engine_u.post(`EV_TX_LOST_ARB);
    engine_u.post(`EV_TX_BUS_ERR);
    waitc(3);
    rd(4'h4, 32'h0000_00E0, 32'h0000_0060);
    wr(4'h4, 4'h1, 32'h0000_0000);
    rd(4'h4, 32'h0000_00E0, 32'h0000_0000);
    engine_u.post(`EV_TX_ATTEMPTS);
    waitc(3);
    rd(4'h4, 32'h0000_0010, 32'h0000_0010);
    check(sendPending, 1'h0);
    wr(4'h0, 4'h1, 32'h0000_0040);
    engine_u.post(`EV_TX_LOST_ARB);
    engine_u.post(`EV_REMOTE_REQ);
    waitc(3);
    check(sendPending, 1'h1);
    rd(4'h4, 32'h0000_00E0, 32'h0000_0000);
    $display("test tx_outcome done");
    configMode = 1'b1;
    wr(4'h0, 4'h9, 32'h0300_0028);
    for (i = 0; i < 16; i = i + 1) engine_u.post(`EV_TX_DONE);
    check(evReady, 1'h0);
    configMode = 1'b0;
    waitc(24);
    check(evReady, 1'h1);
    check(captureTimestamp, 1'h1);
    wr(4'h0, 4'h2, 32'h0000_0200);
    check(sendPending, 1'h0);
    for (i = 0; i < 4; i = i + 1) engine_u.post(`EV_RX_STORE);
    waitc(3);
    rd(4'h4, 32'hFFFF_FFFF, 32'h0000_0007);
    check(intReq, 1'h0);
    engine_u.post(`EV_RX_STORE);
    waitc(3);
    rd(4'h4, 32'hFFFF_FFFF, 32'h0000_000F);
    check(intReq, 1'h1);
    wr(4'h0, 4'h2, 32'h0000_0100);
    rd(4'h8, 32'hFFFF_FFFF, 32'h0000_0414);
    rd(4'h4, 32'hFFFF_FFFF, 32'h0000_000B);
    $display("test rx_path done");
    wr(4'h0, 4'h2, 32'h0000_0400);
    peek(4'h0);
    for (i = 0; i < 8 && regRdata[10] !== 1'b0; i = i + 1) peek(4'h0);
    check(i < 8, 1'h1);
    rd(4'h0, 32'h0000_0400, 32'h0000_0000);
    rd(4'h4, 32'hFFFF_FFFF, 32'h0000_0000);
    check(intReq, 1'h0);
    engine_u.post(`EV_RX_OVERFLOW);
    waitc(3);
    rd(4'h4, 32'hFFFF_FFFF, 32'h0000_0008);
    check(intReq, 1'h1);
    $display("test fifo_reset done");
    report_and_stop;
  end
endmodule
